/* File: design/seq_pkg.sv */
// Purpose: shared constants and types of the capture sequencer
// Assumes: 32-bit register bus, one word per register
// Notes:   offsets are byte addresses
package seq_pkg;
  // ==========================================
  // widths and counts
  localparam int ADDR_W             = 8;
  localparam int RES_W              = 12;
  localparam int ACC_W              = 16;
  localparam int HP_SUMS            = 16;
  localparam int SCL_EDGES_PER_CONV = 18;
  // ==========================================
  // register offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] CONFIG_OFS   = 8'h04;
  localparam logic [7:0] INTERVAL_OFS = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0C;
  localparam logic [7:0] ACC_OFS      = 8'h10;
  localparam logic [7:0] BUF_OFS      = 8'h40;
  localparam logic [7:0] BUF_END      = 8'h7C;
  // ==========================================
  // field positions
  localparam int LAUNCH_BIT   = 0;
  localparam int ABORT_BIT    = 1;
  localparam int MODE_LSB     = 0;
  localparam int POLICY_LSB   = 4;
  localparam int SCAN_LSB     = 8;
  localparam int OSC_BIT      = 12;
  localparam int ACCEN_LSB    = 16;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_FULL_BIT  = 1;
  localparam int ST_ACCV_BIT  = 2;
  localparam int ST_ALERT_BIT = 3;
  localparam int ST_COUNT_LSB = 8;
  // ==========================================
  // reset values and masks
  localparam logic [31:0] CONFIG_RESET   = 32'h0000_0100;
  localparam logic [31:0] CONFIG_MASK    = 32'h0003_1377;
  localparam logic [7:0]  INTERVAL_RESET = 8'h00;
  // ==========================================
  // codes
  localparam logic [2:0] MODE_AUTO       = 3'h6;
  localparam logic [2:0] MODE_HIGH_PREC  = 3'h7;
  localparam logic [2:0] POL_STOP_BURST  = 3'h0;
  localparam logic [2:0] POL_START_BURST = 3'h1;
  localparam logic [2:0] POL_PRE_ALERT   = 3'h4;
  localparam logic [2:0] POL_POST_ALERT  = 3'h6;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CONVERT = 2'b01,
    ST_GAP     = 2'b10
  } seq_state_t;
endpackage

/* File: design/chan_accumulator.sv */
// Purpose: running sum of one channel's conversion results
// Assumes: at most sixteen additions between clears
// Notes:   no saturation needed, sixteen full-scale results fit
`timescale 1ns/1ps
module chan_accumulator #(
  parameter int IN_W  = 12,
  parameter int SUM_W = 16
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // control and data
  input  wire logic             clear,
  input  wire logic             add_en,
  input  wire logic [IN_W-1:0]  sample,
  output logic      [SUM_W-1:0] sum
);
  logic [SUM_W-1:0] sum_q;
  logic [SUM_W-1:0] sum_d;

  if (SUM_W < IN_W + 4)
  begin : g_bad_width
    $error("SUM_W too narrow for sixteen samples");
  end

  // ==========================================
  // sum
  always_comb
  begin
    sum_d = sum_q;
    if (clear)
      sum_d = '0;
    else if (add_en)
      sum_d = sum_q + SUM_W'(sample);
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
      sum_q <= '0;
    else
      sum_q <= sum_d;
  end

  assign sum = sum_q;
endmodule

/* File: design/autonomous_capture_sequencer.sv */
// Purpose: autonomous and high-precision conversion sequencer
// Assumes: converter and comparator on the same clock, scl from a pin
// Notes:   registers over an AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module autonomous_capture_sequencer #(
  parameter int BUF_DEPTH   = 16,
  parameter int LOW_OSC_DIV = 16
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  // register bus, write
  input  wire logic [seq_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // register bus, read
  input  wire logic [seq_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // converter
  output logic                            conv_start,
  output logic                            conv_channel,
  input  wire logic                       conv_done,
  input  wire logic [seq_pkg::RES_W-1:0]  conv_result,
  // threshold comparator
  input  wire logic [1:0]                 thresh_high_flags,
  input  wire logic [1:0]                 thresh_low_flags,
  // serial bus clock pin
  input  wire logic                       scl_in,
  // completion
  output logic                            busy_ready
);
  import seq_pkg::*;

  localparam int PTR_W = $clog2(BUF_DEPTH);
  localparam int CNT_W = PTR_W + 1;
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR = PTR_W'(BUF_DEPTH - 1);
  localparam logic [4:0] SCL_LAST = 5'(SCL_EDGES_PER_CONV - 1);
  localparam logic [7:0] PRESC_TOP = 8'(LOW_OSC_DIV - 1);

  if (BUF_DEPTH < 2 || BUF_DEPTH > 16 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("BUF_DEPTH must be a power of two from 2 to 16");
  end
  if (LOW_OSC_DIV < 2 || LOW_OSC_DIV > 256)
  begin : g_bad_div
    $error("LOW_OSC_DIV must lie from 2 to 256");
  end

  // ==========================================
  // declarations
  logic              aw_held_q, aw_held_d, w_held_q, w_held_d;
  logic [ADDR_W-1:0] waddr_q, waddr_d;
  logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awready_q, awready_d, wready_q, wready_d;
  logic              bvalid_q, bvalid_d, arready_q, arready_d;
  logic              rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]       config_q, config_d, cfg_mask;
  logic [7:0]        interval_q, interval_d;
  logic              launch_p, abort_p;
  logic [31:0]       rd_word, status_word;
  logic              rd_err;

  seq_state_t        state_q, state_d;
  logic              busy_q, busy_d, ch_q, ch_d;
  logic              start_q, start_d;
  logic [RES_W-1:0]  buf_q [BUF_DEPTH];
  logic [RES_W-1:0]  buf_d [BUF_DEPTH];
  logic [PTR_W-1:0]  ptr_q, ptr_d;
  logic [CNT_W-1:0]  count_q, count_d;
  logic              alert_seen_q, alert_seen_d;
  logic [7:0]        gap_q, gap_d, presc_q, presc_d;
  logic [4:0]        scl_cnt_q, scl_cnt_d;
  logic [5:0]        hp_cnt_q, hp_cnt_d, hp_last;
  logic              acc_valid_q, acc_valid_d;
  logic              scl_s1_q, scl_s2_q, scl_s3_q;
  logic              acc_clear, buf_we, store_ok, osc_tick, scl_rise;
  logic [1:0]        acc_add;
  logic [ACC_W-1:0]  acc_sum [2];

  logic [2:0] mode, policy;
  logic [1:0] scan, acc_allow;
  logic       hp, auto_m, manual, dual, alert_hit;

  assign mode      = config_q[MODE_LSB +: 3];
  assign policy    = config_q[POLICY_LSB +: 3];
  assign scan      = config_q[SCAN_LSB +: 2];
  assign acc_allow = config_q[ACCEN_LSB +: 2];
  assign hp        = (mode == MODE_HIGH_PREC);
  assign auto_m    = (mode == MODE_AUTO);
  assign manual    = !hp && !auto_m;
  assign dual      = &scan;
  assign alert_hit = |((thresh_high_flags | thresh_low_flags) & scan);
  assign hp_last   = dual ? 6'(2 * HP_SUMS - 1) : 6'(HP_SUMS - 1);
  assign cfg_mask  = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                      {8{wstrb_q[0]}}} & CONFIG_MASK;

  // ==========================================
  // read decode
  always_comb
  begin
    status_word = '0;
    status_word[ST_BUSY_BIT]  = busy_q;
    status_word[ST_FULL_BIT]  = (count_q == FULL_CNT);
    status_word[ST_ACCV_BIT]  = acc_valid_q;
    status_word[ST_ALERT_BIT] = alert_seen_q;
    status_word[ST_COUNT_LSB +: CNT_W] = count_q;
    rd_word = '0;
    rd_err  = 1'b0;
    if (araddr >= BUF_OFS && araddr <= BUF_END && araddr[1:0] == 2'h0)
    begin
      // buffer reads as zero in high-precision mode
      if (!hp && int'(araddr[5:2]) < BUF_DEPTH)
        rd_word = 32'(buf_q[araddr[PTR_W+1:2]]);
    end
    else
    begin
      case (araddr)
        CTRL_OFS:     rd_word = '0;
        CONFIG_OFS:   rd_word = config_q;
        INTERVAL_OFS: rd_word = 32'(interval_q);
        STATUS_OFS:   rd_word = status_word;
        ACC_OFS:      rd_word = {acc_sum[1], acc_sum[0]};
        default:      rd_err  = 1'b1;
      endcase
    end
  end

  // ==========================================
  // register bus slave
  always_comb
  begin
    aw_held_d  = aw_held_q;
    w_held_d   = w_held_q;
    waddr_d    = waddr_q;
    wdata_d    = wdata_q;
    wstrb_d    = wstrb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rvalid_d   = rvalid_q;
    rdata_d    = rdata_q;
    rresp_d    = rresp_q;
    config_d   = config_q;
    interval_d = interval_q;
    launch_p   = 1'b0;
    abort_p    = 1'b0;
    if (awvalid && awready_q)
    begin
      aw_held_d = 1'b1;
      waddr_d   = awaddr;
    end
    if (wvalid && wready_q)
    begin
      w_held_d = 1'b1;
      wdata_d  = wdata;
      wstrb_d  = wstrb;
    end
    if (bvalid_q && bready)
      bvalid_d = 1'b0;
    if (aw_held_q && w_held_q && !bvalid_q)
    begin
      aw_held_d = 1'b0;
      w_held_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (waddr_q)
        CTRL_OFS:
        begin
          launch_p = wstrb_q[0] && wdata_q[LAUNCH_BIT];
          abort_p  = wstrb_q[0] && wdata_q[ABORT_BIT];
        end
        CONFIG_OFS:   config_d = (config_q & ~cfg_mask) | (wdata_q & cfg_mask);
        INTERVAL_OFS: interval_d = wstrb_q[0] ? wdata_q[7:0] : interval_q;
        STATUS_OFS:   bresp_d = RESP_OKAY;
        ACC_OFS:      bresp_d = RESP_OKAY;
        default:      bresp_d = RESP_SLVERR;
      endcase
    end
    awready_d = !aw_held_d && !bvalid_d;
    wready_d  = !w_held_d && !bvalid_d;
    if (rvalid_q && rready)
      rvalid_d = 1'b0;
    if (arvalid && arready_q)
    begin
      rvalid_d = 1'b1;
      rdata_d  = rd_word;
      rresp_d  = rd_err ? RESP_SLVERR : RESP_OKAY;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      waddr_q    <= '0;
      wdata_q    <= '0;
      wstrb_q    <= '0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= '0;
      rresp_q    <= RESP_OKAY;
      config_q   <= CONFIG_RESET;
      interval_q <= INTERVAL_RESET;
    end
    else
    begin
      aw_held_q  <= aw_held_d;
      w_held_q   <= w_held_d;
      waddr_q    <= waddr_d;
      wdata_q    <= wdata_d;
      wstrb_q    <= wstrb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rdata_q    <= rdata_d;
      rresp_q    <= rresp_d;
      config_q   <= config_d;
      interval_q <= interval_d;
    end
  end

  // ==========================================
  // sequencer
  always_comb
  begin
    state_d      = state_q;
    busy_d       = busy_q;
    ch_d         = ch_q;
    start_d      = 1'b0;
    buf_d        = buf_q;
    ptr_d        = ptr_q;
    count_d      = count_q;
    alert_seen_d = alert_seen_q;
    gap_d        = gap_q;
    scl_cnt_d    = scl_cnt_q;
    hp_cnt_d     = hp_cnt_q;
    acc_valid_d  = acc_valid_q;
    acc_clear    = 1'b0;
    acc_add      = 2'b00;
    buf_we       = 1'b0;
    // slow oscillator is a divided tick of the fast one
    osc_tick = !config_q[OSC_BIT] || presc_q == 8'h00;
    presc_d  = !config_q[OSC_BIT] ? 8'h00 : (presc_q == 8'h00 ? PRESC_TOP : presc_q - 8'h01);
    scl_rise = scl_s2_q && !scl_s3_q;
    store_ok = !auto_m || policy != POL_POST_ALERT || alert_seen_q || alert_hit;
    if (alert_hit && state_q != ST_IDLE)
      alert_seen_d = 1'b1;
    case (state_q)
      ST_IDLE:
      begin
        if (launch_p && !abort_p)
        begin
          ptr_d        = '0;
          count_d      = '0;
          hp_cnt_d     = '0;
          alert_seen_d = 1'b0;
          acc_valid_d  = 1'b0;
          acc_clear    = 1'b1;
          busy_d       = 1'b1;
          ch_d         = (scan == 2'b10);
          scl_cnt_d    = '0;
          state_d      = manual ? ST_GAP : ST_CONVERT;
          start_d      = !manual;
        end
      end
      ST_CONVERT:
      begin
        if (conv_done)
        begin
          ch_d      = dual ? !ch_q : ch_q;
          state_d   = ST_GAP;
          gap_d     = interval_q;
          scl_cnt_d = '0;
          if (hp)
          begin
            // a disabled accumulator keeps its cleared value
            acc_add[ch_q] = acc_allow[ch_q];
            hp_cnt_d = hp_cnt_q + 6'h01;
            if (hp_cnt_q == hp_last)
            begin
              state_d     = ST_IDLE;
              busy_d      = 1'b0;
              acc_valid_d = 1'b1;
            end
          end
          else if (store_ok)
          begin
            buf_we = 1'b1;
            buf_d[ptr_q] = conv_result;
            ptr_d = (ptr_q == LAST_PTR) ? '0 : ptr_q + 1'b1;
            if (count_q != FULL_CNT)
              count_d = count_q + 1'b1;
            if (auto_m && count_q == FULL_CNT - 1'b1 &&
                (policy == POL_START_BURST || policy == POL_POST_ALERT))
            begin
              state_d = ST_IDLE;
              busy_d  = 1'b0;
            end
          end
        end
      end
      ST_GAP:
      begin
        if (manual)
        begin
          // one conversion per frame of serial clock edges
          if (scl_rise)
          begin
            scl_cnt_d = scl_cnt_q + 5'h01;
            if (scl_cnt_q == SCL_LAST)
            begin
              state_d = ST_CONVERT;
              start_d = 1'b1;
            end
          end
        end
        else if (gap_q == 8'h00)
        begin
          state_d = ST_CONVERT;
          start_d = 1'b1;
        end
        else if (osc_tick)
          gap_d = gap_q - 8'h01;
      end
      default: state_d = ST_IDLE;
    endcase
    if (auto_m && policy == POL_PRE_ALERT && alert_hit && state_q != ST_IDLE)
    begin
      state_d = ST_IDLE;
      busy_d  = 1'b0;
      start_d = 1'b0;
    end
    if (abort_p && state_q != ST_IDLE)
    begin
      state_d     = ST_IDLE;
      busy_d      = 1'b0;
      start_d     = 1'b0;
      acc_valid_d = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!reset_n)
    begin
      state_q      <= ST_IDLE;
      busy_q       <= 1'b0;
      ch_q         <= 1'b0;
      start_q      <= 1'b0;
      buf_q        <= '{default: '0};
      ptr_q        <= '0;
      count_q      <= '0;
      alert_seen_q <= 1'b0;
      gap_q        <= '0;
      presc_q      <= '0;
      scl_cnt_q    <= '0;
      hp_cnt_q     <= '0;
      acc_valid_q  <= 1'b0;
      scl_s1_q     <= 1'b0;
      scl_s2_q     <= 1'b0;
      scl_s3_q     <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      busy_q       <= busy_d;
      ch_q         <= ch_d;
      start_q      <= start_d;
      buf_q        <= buf_d;
      ptr_q        <= ptr_d;
      count_q      <= count_d;
      alert_seen_q <= alert_seen_d;
      gap_q        <= gap_d;
      presc_q      <= presc_d;
      scl_cnt_q    <= scl_cnt_d;
      hp_cnt_q     <= hp_cnt_d;
      acc_valid_q  <= acc_valid_d;
      scl_s1_q     <= scl_in;
      scl_s2_q     <= scl_s1_q;
      scl_s3_q     <= scl_s2_q;
    end
  end

  // ==========================================
  // accumulators
  for (genvar c = 0; c < 2; c++)
  begin : g_acc
    chan_accumulator #(
      .IN_W  (RES_W),
      .SUM_W (ACC_W)
    ) u_acc (
      .clock   (clock),
      .reset_n (reset_n),
      .clear   (acc_clear),
      .add_en  (acc_add[c]),
      .sample  (conv_result),
      .sum     (acc_sum[c])
    );
  end

  // ==========================================
  // outputs
  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign conv_start   = start_q;
  assign conv_channel = ch_q;
  assign busy_ready   = busy_q;

  // ==========================================
  // checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  pre_alert_halt_a: assert property (
    auto_m && policy == POL_PRE_ALERT && alert_hit && state_q != ST_IDLE && !abort_p
    |=> state_q == ST_IDLE && !busy_ready && !conv_start)
    else $error("pre-alert sequence kept running after alert");
  abort_ends_a: assert property (
    abort_p && state_q != ST_IDLE |=> state_q == ST_IDLE ##1 !conv_start [*3])
    else $error("abort did not end the sequence");
  ptr_wrap_a: assert property (
    buf_we && ptr_q == LAST_PTR |=> ptr_q == '0 && count_q == FULL_CNT)
    else $error("buffer pointer did not wrap");
  post_gate_a: assert property (
    auto_m && policy == POL_POST_ALERT && !alert_seen_q && !alert_hit |-> !buf_we)
    else $error("post-alert stored before alert");
  burst_full_a: assert property (
    buf_we && auto_m && policy == POL_START_BURST && count_q == FULL_CNT - 1'b1
    && !abort_p |=> state_q == ST_IDLE && $fell(busy_ready))
    else $error("start burst did not stop when full");
  hp_done_a: assert property (
    hp && state_q == ST_CONVERT && conv_done && hp_cnt_q == hp_last && !abort_p
    |=> acc_valid_q && $fell(busy_ready))
    else $error("accumulation end not signalled");
  hp_invalid_a: assert property (
    abort_p && state_q != ST_IDLE |=> !acc_valid_q)
    else $error("aborted accumulation marked valid");
  hp_zero_read_a: assert property (
    arvalid && arready && hp && araddr >= BUF_OFS && araddr <= BUF_END
    |=> rvalid && rdata == 32'h0000_0000)
    else $error("buffer read not zero in high precision");
  gap_start_a: assert property (
    state_q == ST_GAP && !manual && gap_q == 8'h00 && !abort_p
    && !(auto_m && policy == POL_PRE_ALERT && alert_hit) |=> conv_start)
    else $error("conversion not started after interval");
endmodule

/* File: testbench/conv_model.sv */
// Purpose: converter stand-in, one answer per start request
// Assumes: same clock as the sequencer
// Notes:   result is a per-channel value chosen by the bench
`timescale 1ns/1ps
module conv_model (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // request and values
  input  wire logic                      conv_start,
  input  wire logic                      conv_channel,
  input  wire logic [seq_pkg::RES_W-1:0] val0,
  input  wire logic [seq_pkg::RES_W-1:0] val1,
  // answer
  output logic                           conv_done,
  output logic [seq_pkg::RES_W-1:0]      conv_result
);
  import seq_pkg::*;
  // ==========================================
  // fixed two-cycle conversion
  logic [1:0]       pipe_q;
  logic             chan_q;
  logic [RES_W-1:0] last_q;
  always @(posedge clock)
  begin
    pipe_q <= reset_n ? {pipe_q[0], conv_start} : 2'h0;
    if (conv_start)
      chan_q <= conv_channel;
    if (conv_done)
      last_q <= conv_result;
  end
  assign conv_done   = pipe_q[1];
  // outside the answer cycle the data flips, so a stale read shows
  assign conv_result = conv_done ? (chan_q ? val1 : val0) : ~last_q;
endmodule

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the capture sequencer
// Assumes: register bus master and converter model on one clock
// Notes:   slow oscillator divider shortened to 2
`timescale 1ns/1ps
module tb_top;
  import seq_pkg::*;
  // ==========================================
  // signals
  logic              clock, reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready, conv_start, conv_channel;
  logic              conv_done, scl_in, busy_ready, scl_run, alt_on;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd_q;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, resp_q, thresh_high_flags, thresh_low_flags;
  logic [RES_W-1:0]  conv_result, val0, val1;
  int                fail_count, comparisons, cycles, n_start, alt_n, n0;
  // ==========================================
  // instances
  autonomous_capture_sequencer #(.BUF_DEPTH(16), .LOW_OSC_DIV(2)) u_dut (
    .clock, .reset_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .conv_start, .conv_channel, .conv_done, .conv_result, .thresh_high_flags,
    .thresh_low_flags, .scl_in, .busy_ready);
  conv_model u_conv (.clock, .reset_n, .conv_start, .conv_channel, .val0, .val1,
    .conv_done, .conv_result);
  // ==========================================
  // clocks and watchdog
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // the serial clock only runs inside a manual frame
  always #24 if (scl_run) scl_in = ~scl_in;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      close_out();
    end
  end
  always @(posedge clock)
    if (conv_start === 1'b1)
    begin
      n_start++;
      if (alt_on)
      begin
        chk("channel", {31'h0, conv_channel}, {31'h0, alt_n[0]});
        alt_n++;
      end
    end
  // ==========================================
  // tasks
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp_q = bresp;
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clock);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_q   = rdata;
    resp_q = rresp;
    rready <= 1'b0;
  endtask
  task cfg(input logic [31:0] c);
    wr(CTRL_OFS, 32'h2);
    wr(CONFIG_OFS, c);
  endtask
  task go;
    wr(CTRL_OFS, 32'h1);
    do @(posedge clock); while (busy_ready !== 1'b0);
  endtask
  task close_out;
    if (fail_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // sequence
  initial
  begin
    {reset_n, awvalid, wvalid, bready, arvalid, rready, scl_run, alt_on, scl_in} = 9'h0;
    {thresh_high_flags, thresh_low_flags} = 4'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hF;
    val0  = 12'h5A5;
    val1  = 12'h001;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    rd(CONFIG_OFS);
    chk("config reset", rd_q, CONFIG_RESET);
    rd(INTERVAL_OFS);
    chk("interval reset", rd_q, 32'h0);
    rd(8'hFC);
    chk("unmapped read", {30'h0, resp_q}, {30'h0, RESP_SLVERR});
    wr(BUF_OFS, 32'h1);
    chk("buffer write", {30'h0, resp_q}, {30'h0, RESP_SLVERR});
    // start burst on slow oscillator with a gap
    wr(INTERVAL_OFS, 32'h3);
    cfg(32'h0000_1116);
    n0 = cycles;
    go();
    // sixteen gaps of three slow ticks, two cycles each, plus two cycles of conversion
    chk("slow pace", {31'h0, cycles - n0 >= 16 * (3 * 2 + 2)}, 32'h1);
    rd(STATUS_OFS);
    chk("start burst status", rd_q, 32'h0000_1002);
    rd(BUF_END);
    chk("last entry", rd_q, 32'h0000_05A5);
    // stop burst, both channels, aborted after many wraps
    wr(INTERVAL_OFS, 32'h0);
    cfg(32'h0000_0306);
    alt_on = 1'b1;
    wr(CTRL_OFS, 32'h1);
    repeat (150) @(posedge clock);
    wr(CTRL_OFS, 32'h2);
    repeat (2) @(posedge clock);
    alt_on = 1'b0;
    chk("abort busy", {31'h0, busy_ready}, 32'h0);
    rd(STATUS_OFS);
    chk("stop burst status", rd_q, 32'h0000_1002);
    rd(BUF_OFS);
    chk("first entry channel 0", rd_q, 32'h0000_05A5);
    rd(BUF_OFS + 8'h04);
    chk("second entry channel 1", rd_q, 32'h0000_0001);
    // pre-alert: more than sixteen before the flag
    cfg(32'h0000_0146);
    wr(CTRL_OFS, 32'h1);
    repeat (150) @(posedge clock);
    thresh_high_flags <= 2'h1;
    do @(posedge clock); while (busy_ready !== 1'b0);
    thresh_high_flags <= 2'h0;
    rd(STATUS_OFS);
    chk("pre alert status", rd_q, 32'h0000_100A);
    // post-alert: nothing stored before the flag
    cfg(32'h0000_0166);
    wr(CTRL_OFS, 32'h1);
    repeat (60) @(posedge clock);
    rd(STATUS_OFS);
    chk("post alert wait", rd_q, 32'h0000_0001);
    thresh_low_flags <= 2'h1;
    do @(posedge clock); while (busy_ready !== 1'b0);
    thresh_low_flags <= 2'h0;
    rd(STATUS_OFS);
    chk("post alert status", rd_q, 32'h0000_100A);
    // high precision, both channels
    val0 <= 12'hFFF;
    cfg(32'h0003_0307);
    go();
    rd(ACC_OFS);
    chk("sums", rd_q, 32'h0010_FFF0);
    rd(STATUS_OFS);
    chk("sum valid", {31'h0, rd_q[ST_ACCV_BIT]}, 32'h1);
    rd(BUF_OFS);
    chk("buffer read", rd_q, 32'h0);
    wr(CTRL_OFS, 32'h1);
    repeat (20) @(posedge clock);
    wr(CTRL_OFS, 32'h2);
    rd(STATUS_OFS);
    chk("aborted sum", {31'h0, rd_q[ST_ACCV_BIT]}, 32'h0);
    // manual mode paced by the serial clock
    cfg(32'h0000_0100);
    scl_run = 1'b1;
    wr(CTRL_OFS, 32'h1);
    n0 = n_start;
    repeat (140) @(posedge clock);
    chk("manual early", n_start, n0);
    repeat (100) @(posedge clock);
    chk("manual pace", {31'h0, n_start > n0}, 32'h1);
    wr(CTRL_OFS, 32'h2);
    scl_run = 1'b0;
    close_out();
  end
endmodule
